//--- hw/tmcf_pkg.sv
// constants for the timer counter, modulo and channel flag block
package tmcf_pkg;
	localparam int ADDR_W = 3;
	localparam int DATA_W = 8;
	localparam int CNT_W = 16;
	localparam int PRE_W = 7;
	// byte register indices
	localparam logic [2:0] A_MSC = 3'h0;
	localparam logic [2:0] A_CNT_HI = 3'h1;
	localparam logic [2:0] A_CNT_LO = 3'h2;
	localparam logic [2:0] A_MOD_HI = 3'h3;
	localparam logic [2:0] A_MOD_LO = 3'h4;
	localparam logic [2:0] A_CSC = 3'h5;
	localparam logic [2:0] A_CHV_HI = 3'h6;
	localparam logic [2:0] A_CHV_LO = 3'h7;
	// main_status_control fields
	localparam int MSC_TOF = 7;
	localparam int MSC_TOIE = 6;
	localparam int MSC_CENTER_ALIGNED_SELECT = 5;
	localparam int MSC_CLKS_HI = 4;
	localparam int MSC_CLKS_LO = 3;
	localparam int MSC_PS_HI = 2;
	// channel_status_control fields
	localparam int CSC_FLAG = 7;
	localparam int CSC_IE = 6;
	localparam int CSC_MSB = 5;
	localparam int CSC_MSA = 4;
	localparam int CSC_ELS_HI = 3;
	localparam int CSC_ELS_LO = 2;
	// clock_source_select codes
	localparam logic [1:0] CLK_NONE = 2'h0;
	localparam logic [1:0] CLK_BUS = 2'h1;
	localparam logic [1:0] CLK_FIXED = 2'h2;
	localparam logic [1:0] CLK_EXT = 2'h3;
	// edge selects in capture mode
	localparam logic [1:0] ELS_RISE = 2'h1;
	localparam logic [1:0] ELS_FALL = 2'h2;
	localparam logic [1:0] ELS_BOTH = 2'h3;
	localparam logic [15:0] CNT_ZERO = 16'h0000;
	localparam logic [15:0] CNT_ONE = 16'h0001;
	localparam logic [15:0] CNT_FULL = 16'hffff;
	localparam logic [15:0] MOD_RST = 16'h0000;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [6:0] PRE_ZERO = 7'h00;
	localparam logic [6:0] PRE_ONE = 7'h01;
endpackage

//--- hw/tmcf_top.sv
// timer counter with modulo, coherent byte access and one channel flag
//
// Design decisions made here: the address map and the address-and-strobe port.
module tmcf_top (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [tmcf_pkg::ADDR_W-1:0] addr,
	input wire logic [tmcf_pkg::DATA_W-1:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [tmcf_pkg::DATA_W-1:0] rdata,
	input wire logic debug_halt,
	input wire logic fixed_tick,
	input wire logic ext_tick,
	input wire logic capture_in,
	output logic overflow_irq,
	output logic channel_irq
);
	import tmcf_pkg::*;

	typedef struct packed {
		logic overflow_flag;
		logic toie;
		logic center_aligned_select;
		logic [1:0] clks;
		logic [2:0] ps;
		logic tof_arm;
		logic [CNT_W-1:0] cnt;
		logic down;
		logic [PRE_W-1:0] pre;
		logic cl_valid;
		logic cl_wait_lo;
		logic [CNT_W-1:0] cl_val;
		logic [CNT_W-1:0] modv;
		logic [CNT_W-1:0] mbuf;
		logic m_hi;
		logic m_lo;
		logic m_pend;
		logic ch_f;
		logic ch_ie;
		logic ch_msb;
		logic ch_msa;
		logic [1:0] ch_els;
		logic ch_arm;
		logic [CNT_W-1:0] chv;
		logic cap_d;
		logic [DATA_W-1:0] rdata;
		logic tof_irq;
		logic ch_irq;
	} tmcf_state_t;

	tmcf_state_t s_r;
	tmcf_state_t s_nxt;

	logic src_tick;
	logic tick;
	logic [PRE_W-1:0] pre_max;
	logic [CNT_W-1:0] top;
	logic ovf_evt;
	logic ch_evt;
	logic cap_edge;
	logic match_ok;
	logic pwm_mode;
	logic [CNT_W-1:0] rd_cnt;

	assign rdata = s_r.rdata;
	assign overflow_irq = s_r.tof_irq;
	assign channel_irq = s_r.ch_irq;

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		s_nxt = s_r;
		// clock source selection and prescaler
		unique case (s_r.clks)
			CLK_NONE: src_tick = 1'b0;
			CLK_BUS: src_tick = 1'b1;
			CLK_FIXED: src_tick = fixed_tick;
			CLK_EXT: src_tick = ext_tick;
		endcase
		pre_max = PRE_W'((PRE_ONE << s_r.ps) - PRE_ONE);
		tick = src_tick && !debug_halt && (s_r.pre == pre_max);
		if (src_tick && !debug_halt) begin
			s_nxt.pre = (s_r.pre == pre_max) ? PRE_ZERO : PRE_W'(s_r.pre + PRE_ONE);
		end
		top = (s_r.modv == CNT_ZERO) ? CNT_FULL : s_r.modv;
		ovf_evt = 1'b0;
		if (tick) begin
			if (s_r.center_aligned_select) begin
				if (!s_r.down) begin
					if (s_r.cnt == top) begin
						s_nxt.down = 1'b1;
						s_nxt.cnt = CNT_W'(s_r.cnt - CNT_ONE);
						ovf_evt = 1'b1;
					end else begin
						s_nxt.cnt = CNT_W'(s_r.cnt + CNT_ONE);
					end
				end else if (s_r.cnt == CNT_ZERO) begin
					s_nxt.down = 1'b0;
					s_nxt.cnt = CNT_ONE;
				end else begin
					s_nxt.cnt = CNT_W'(s_r.cnt - CNT_ONE);
				end
			end else if (s_r.cnt == top) begin
				s_nxt.cnt = CNT_ZERO;
				ovf_evt = 1'b1;
			end else begin
				s_nxt.cnt = CNT_W'(s_r.cnt + CNT_ONE);
			end
			// buffered modulo moves in as the counter steps onto the old top
			if (s_r.m_pend && !s_r.down && s_r.cnt == CNT_W'(top - CNT_ONE)) begin
				s_nxt.modv = s_r.mbuf;
				s_nxt.m_pend = 1'b0;
			end
		end

		////////////////////////////////////////////////////////////////////////
		// channel events
		pwm_mode = s_r.center_aligned_select || s_r.ch_msb;
		cap_edge = 1'b0;
		unique case (s_r.ch_els)
			ELS_RISE: cap_edge = capture_in && !s_r.cap_d;
			ELS_FALL: cap_edge = !capture_in && s_r.cap_d;
			ELS_BOTH: cap_edge = capture_in != s_r.cap_d;
			default: cap_edge = 1'b0;
		endcase
		// a 0% or 100% duty never toggles, so its match is not an event
		match_ok = !pwm_mode || (s_r.chv != CNT_ZERO && s_r.chv <= s_r.modv);
		ch_evt = 1'b0;
		if (!pwm_mode && !s_r.ch_msa) begin
			ch_evt = cap_edge;
			if (cap_edge) begin
				s_nxt.chv = s_r.cnt;
			end
		end else begin
			ch_evt = tick && (s_r.cnt == s_r.chv) && match_ok;
		end
		s_nxt.cap_d = capture_in;

		////////////////////////////////////////////////////////////////////////
		// register reads
		rd_cnt = s_r.cl_valid ? s_r.cl_val : s_r.cnt;
		if (rd_en) begin
			unique case (addr)
				A_MSC: s_nxt.rdata = {s_r.overflow_flag, s_r.toie, s_r.center_aligned_select, s_r.clks, s_r.ps};
				A_CNT_HI: s_nxt.rdata = rd_cnt[15:8];
				A_CNT_LO: s_nxt.rdata = rd_cnt[7:0];
				A_MOD_HI: s_nxt.rdata = s_r.modv[15:8];
				A_MOD_LO: s_nxt.rdata = s_r.modv[7:0];
				A_CSC: s_nxt.rdata = {s_r.ch_f, s_r.ch_ie, s_r.ch_msb, s_r.ch_msa,
					s_r.ch_els, 2'h0};
				A_CHV_HI: s_nxt.rdata = s_r.chv[15:8];
				A_CHV_LO: s_nxt.rdata = s_r.chv[7:0];
			endcase
			if (addr == A_MSC && s_r.overflow_flag) begin
				s_nxt.tof_arm = 1'b1;
			end
			if (addr == A_CSC && s_r.ch_f) begin
				s_nxt.ch_arm = 1'b1;
			end
			// the holding buffer is frozen while halted
			if ((addr == A_CNT_HI || addr == A_CNT_LO) && !debug_halt) begin
				if (!s_r.cl_valid) begin
					s_nxt.cl_valid = 1'b1;
					s_nxt.cl_val = s_r.cnt;
					s_nxt.cl_wait_lo = (addr == A_CNT_HI);
				end else if (s_r.cl_wait_lo == (addr == A_CNT_LO)) begin
					s_nxt.cl_valid = 1'b0;
				end
			end
		end

		////////////////////////////////////////////////////////////////////////
		// register writes
		if (wr_en) begin
			unique case (addr)
				A_MSC: begin
					s_nxt.toie = wdata[MSC_TOIE];
					s_nxt.center_aligned_select = wdata[MSC_CENTER_ALIGNED_SELECT];
					s_nxt.clks = wdata[MSC_CLKS_HI:MSC_CLKS_LO];
					s_nxt.ps = wdata[MSC_PS_HI:0];
					if (s_r.tof_arm && !wdata[MSC_TOF]) begin
						s_nxt.overflow_flag = 1'b0;
					end
					s_nxt.tof_arm = 1'b0;
					s_nxt.cl_valid = 1'b0;
					s_nxt.m_hi = 1'b0;
					s_nxt.m_lo = 1'b0;
				end
				A_CNT_HI, A_CNT_LO: begin
					s_nxt.cnt = CNT_ZERO;
					s_nxt.down = 1'b0;
					s_nxt.pre = PRE_ZERO;
					s_nxt.cl_valid = 1'b0;
				end
				A_MOD_HI, A_MOD_LO: begin
					if (debug_halt) begin
						// pairing state is held; data bypasses the buffer
						if (addr == A_MOD_HI) begin
							s_nxt.modv[15:8] = wdata;
						end else begin
							s_nxt.modv[7:0] = wdata;
						end
					end else begin
						if (addr == A_MOD_HI) begin
							s_nxt.mbuf[15:8] = wdata;
							s_nxt.m_hi = 1'b1;
						end else begin
							s_nxt.mbuf[7:0] = wdata;
							s_nxt.m_lo = 1'b1;
						end
						if (s_nxt.m_hi && s_nxt.m_lo) begin
							s_nxt.m_hi = 1'b0;
							s_nxt.m_lo = 1'b0;
							if (s_r.clks == CLK_NONE) begin
								s_nxt.modv = s_nxt.mbuf;
								s_nxt.m_pend = 1'b0;
							end else begin
								s_nxt.m_pend = 1'b1;
							end
						end
					end
				end
				A_CSC: begin
					s_nxt.ch_ie = wdata[CSC_IE];
					s_nxt.ch_msb = wdata[CSC_MSB];
					s_nxt.ch_msa = wdata[CSC_MSA];
					s_nxt.ch_els = wdata[CSC_ELS_HI:CSC_ELS_LO];
					if (s_r.ch_arm && !wdata[CSC_FLAG]) begin
						s_nxt.ch_f = 1'b0;
					end
					s_nxt.ch_arm = 1'b0;
				end
				A_CHV_HI: s_nxt.chv[15:8] = wdata;
				A_CHV_LO: s_nxt.chv[7:0] = wdata;
			endcase
		end

		////////////////////////////////////////////////////////////////////////
		// channel events, and overflows unless only one modulo byte is written, win over a clear in the same cycle and restart the sequence
		if (ovf_evt && !(s_r.m_hi ^ s_r.m_lo)) begin
			s_nxt.overflow_flag = 1'b1;
			s_nxt.tof_arm = 1'b0;
		end
		if (ch_evt) begin
			s_nxt.ch_f = 1'b1;
			s_nxt.ch_arm = 1'b0;
		end
		s_nxt.tof_irq = s_nxt.overflow_flag && s_nxt.toie;
		s_nxt.ch_irq = s_nxt.ch_f && s_nxt.ch_ie;
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	chk_cnt_write_clear: assert property (
		wr_en && (addr == A_CNT_HI || addr == A_CNT_LO) |=> s_r.cnt == CNT_ZERO && !s_r.cl_valid)
		else $error("counter byte write did not clear counter");
	chk_halt_freeze: assert property (
		debug_halt && !wr_en |=> $stable(s_r.cnt) && $stable(s_r.cl_valid))
		else $error("counter or holding buffer moved during halt");
	chk_wrap_zero: assert property (
		tick && !s_r.center_aligned_select && s_r.cnt == top && !wr_en |=> s_r.cnt == CNT_ZERO)
		else $error("counter did not wrap at modulo");
	chk_tof_inhibit: assert property (
		(s_r.m_hi != s_r.m_lo) && !s_r.overflow_flag |=> !s_r.overflow_flag)
		else $error("overflow flag set with half-written modulo");
	chk_mod_bypass: assert property (
		debug_halt && wr_en && addr == A_MOD_HI |=> s_r.modv[15:8] == $past(wdata))
		else $error("halted modulo write did not go direct");
	chk_latch_pair: assert property (
		!debug_halt && rd_en && addr == A_CNT_HI && !s_r.cl_valid ##1
		!debug_halt && rd_en && addr == A_CNT_LO && !wr_en
		|=> s_r.rdata == $past(s_r.cl_val[7:0]) && !s_r.cl_valid)
		else $error("coherent counter read broken");
	chk_flag_one_noop: assert property (
		wr_en && addr == A_CSC && wdata[CSC_FLAG] && s_r.ch_f |=> s_r.ch_f)
		else $error("writing one cleared the channel flag");
	chk_ch_irq_level: assert property (
		s_r.ch_f && s_r.ch_ie |-> s_r.ch_irq)
		else $error("channel interrupt missing");
	chk_mod_direct: assert property (
		!debug_halt && s_r.clks == CLK_NONE && wr_en && addr == A_MOD_LO && s_r.m_hi && !s_r.m_lo
		|=> s_r.modv[7:0] == $past(wdata) && !s_r.m_hi)
		else $error("modulo not loaded at second byte");

	////////////////////////////////////////////////////////////////////////////
	// control writes, halt behaviour and counting
	chk_msc_unlatch: assert property (
		wr_en && addr == A_MSC |=> !s_r.cl_valid)
		else $error("status write left counter buffer latched");
	chk_msc_pair_reset: assert property (
		wr_en && addr == A_MSC |=> !s_r.m_hi && !s_r.m_lo)
		else $error("status write left modulo pairing armed");
	chk_tof_set: assert property (
		ovf_evt && !(s_r.m_hi ^ s_r.m_lo) |=> s_r.overflow_flag)
		else $error("overflow flag not set at wrap");
	chk_mod_pend_load: assert property (
		tick && s_r.m_pend && !s_r.down && s_r.cnt == CNT_W'(top - CNT_ONE)
		|=> s_r.modv == $past(s_r.mbuf))
		else $error("pending modulo not loaded at step onto top");
	chk_halt_pair_hold: assert property (
		debug_halt && !(wr_en && addr == A_MSC) |=> $stable(s_r.m_hi) && $stable(s_r.m_lo))
		else $error("modulo pairing moved during halt");
	chk_halt_no_tick: assert property (
		debug_halt |-> !tick)
		else $error("counter ticked during halt");
	chk_no_clock_stop: assert property (
		s_r.clks == CLK_NONE && !wr_en |=> $stable(s_r.cnt))
		else $error("counter moved with no clock source");
	chk_step_one: assert property (
		tick && !s_r.center_aligned_select && s_r.cnt != top && !wr_en |=> s_r.cnt == $past(s_r.cnt) + CNT_ONE)
		else $error("counter did not step by one");
	chk_center_turn: assert property (
		tick && s_r.center_aligned_select && !s_r.down && s_r.cnt == top && !wr_en |=> s_r.down)
		else $error("center mode did not turn at top");
	////////////////////////////////////////////////////////////////////////////
	// channel flag and interrupts
	chk_match_flag: assert property (
		tick && !s_r.center_aligned_select && !s_r.ch_msb && s_r.ch_msa && s_r.cnt == s_r.chv |=> s_r.ch_f)
		else $error("compare match did not set channel flag");
	chk_capture_flag: assert property (
		!s_r.center_aligned_select && !s_r.ch_msb && !s_r.ch_msa && s_r.ch_els == ELS_RISE
		&& capture_in && !s_r.cap_d |=> s_r.ch_f)
		else $error("capture edge did not set channel flag");
	chk_pwm_zero_duty: assert property (
		(s_r.center_aligned_select || s_r.ch_msb) && s_r.chv == CNT_ZERO && !s_r.ch_f
		&& !(wr_en && addr == A_CSC) |=> !s_r.ch_f)
		else $error("channel flag set at zero duty");
	chk_edge_pwm_flag: assert property (
		tick && !s_r.center_aligned_select && s_r.ch_msb && s_r.cnt == s_r.chv && s_r.chv != CNT_ZERO
		&& s_r.chv < s_r.modv |=> s_r.ch_f)
		else $error("edge pwm match did not set channel flag");
	chk_flag_clear: assert property (
		wr_en && addr == A_CSC && s_r.ch_arm && !wdata[CSC_FLAG] && !ch_evt |=> !s_r.ch_f)
		else $error("armed zero write did not clear channel flag");
	chk_tof_irq_level: assert property (
		s_r.overflow_flag && s_r.toie |-> s_r.tof_irq)
		else $error("overflow interrupt missing");

	cov_overflow: cover property ($rose(s_r.overflow_flag));
	cov_center_turn: cover property (s_r.center_aligned_select && $rose(s_r.down));
	cov_capture: cover property (!s_r.ch_msa && !pwm_mode && $rose(s_r.ch_f));
	cov_mod_pend: cover property (s_r.m_pend ##[1:300] !s_r.m_pend);
endmodule

//--- bench/tmcf_host.sv
// processor-side bus master model driving the byte register port
module tmcf_host (
	input wire logic mclk,
	input wire logic [tmcf_pkg::DATA_W-1:0] rdata,
	output logic [tmcf_pkg::ADDR_W-1:0] addr,
	output logic [tmcf_pkg::DATA_W-1:0] wdata,
	output logic wr_en,
	output logic rd_en
);
	import tmcf_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		addr = '0;
		wdata = '0;
		wr_en = 1'b0;
		rd_en = 1'b0;
	end
	////////////////////////////////////////////////////////////////
	// one-cycle strobes; a gap cycle follows so no signal is set twice per step
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge mclk);
		wr_en <= 1'b0;
	endtask
	// read data appear in the cycle after the strobe and hold until the next read
	task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
		@(posedge mclk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge mclk);
		rd_en <= 1'b0;
		#1;
		d = rdata;
	endtask
endmodule

//--- bench/tb.sv
// self-checking bench for the timer counter block
module tb;
	import tmcf_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic debug_halt = 1'b0;
	logic ext_tick = 1'b0;
	logic cap_in = 1'b0;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata;
	logic [DATA_W-1:0] rdata;
	logic wr_en;
	logic rd_en;
	logic overflow_irq;
	logic channel_irq;
	int fail_count = 0;
	int checks = 0;
	int cyc = 0;
	int n;
	logic [7:0] d;
	logic [15:0] m;
	logic [15:0] e;
	initial begin
		forever #2.5 mclk = ~mclk;
	end
	tmcf_host h (.mclk(mclk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr_en(wr_en),
		.rd_en(rd_en));
	tmcf_top dut_u (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
		.rd_en(rd_en), .rdata(rdata), .debug_halt(debug_halt), .fixed_tick(ext_tick),
		.ext_tick(ext_tick), .capture_in(cap_in), .overflow_irq(overflow_irq),
		.channel_irq(channel_irq));
	////////////////////////////////////////////////////////////////
	function automatic logic [15:0] cnt_after(input logic [15:0] s, md, input int k);
		logic [15:0] c;
		c = s;
		// a zero modulo lets the count roll over the full range
		for (int i = 0; i < k; i++) c = (c == md && md != 16'h0000) ? 16'h0000 : c + 16'h0001;
		return c;
	endfunction
	task automatic chk(input logic [7:0] got, exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge mclk) ext_tick <= 1'b1;
		@(posedge mclk) ext_tick <= 1'b0;
		repeat (3) @(posedge mclk);
	endtask
	task automatic summarize;
		if (fail_count == 0 && checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			summarize();
		end
	end
	////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(32'ha6761a05));
		repeat (12) @(posedge mclk);
		rst <= 1'b0;
		h.rd(A_CNT_HI, d); chk(d, 8'h00);
		h.rd(A_CNT_LO, d); chk(d, 8'h00);
		h.rd(A_MOD_HI, d); chk(d, 8'h00);
		h.rd(A_CSC, d); chk(d, 8'h00);
		m = 16'h0020 + 16'($urandom % 96);
		h.wr(A_MOD_LO, m[7:0]);
		h.wr(A_MOD_HI, m[15:8]);
		h.rd(A_MOD_HI, d); chk(d, m[15:8]);
		h.rd(A_MOD_LO, d); chk(d, m[7:0]);
		tick(5);
		h.rd(A_CNT_LO, d); chk(d, 8'h00);
		h.rd(A_CNT_HI, d);
		h.wr(A_CNT_HI, 8'(($urandom)));
		h.wr(A_MSC, 8'h58);
		n = int'($urandom % (int'(m) - 8));
		tick(n);
		e = cnt_after(16'h0000, m, n);
		h.rd(A_CNT_HI, d); chk(d, e[15:8]);
		tick(3);
		h.rd(A_CNT_LO, d); chk(d, e[7:0]);
		e = cnt_after(16'h0000, m, n + 3);
		h.rd(A_CNT_LO, d); chk(d, e[7:0]);
		h.wr(A_MSC, 8'h58);
		tick(2);
		e = cnt_after(16'h0000, m, n + 5);
		h.rd(A_CNT_LO, d); chk(d, e[7:0]);
		h.rd(A_CNT_HI, d);
		tick(int'(m) - n - 5);
		h.rd(A_MSC, d); chk(d[7:6], 2'h1);
		tick(1);
		h.rd(A_CNT_LO, d); chk(d, 8'h00);
		h.rd(A_CNT_HI, d);
		chk({7'h00, overflow_irq}, 8'h01);
		debug_halt <= 1'b1;
		tick(4);
		h.rd(A_CNT_LO, d); chk(d, 8'h00);
		h.rd(A_CNT_HI, d);
		debug_halt <= 1'b0;
		h.wr(A_CHV_HI, 8'h00);
		h.wr(A_CHV_LO, 8'h03);
		h.wr(A_CSC, 8'h50);
		tick(4);
		chk({7'h00, channel_irq}, 8'h01);
		// clearing write without a prior read must not clear
		h.wr(A_CSC, 8'h50);
		repeat (3) @(posedge mclk);
		chk({7'h00, channel_irq}, 8'h01);
		h.rd(A_CSC, d); chk(d[7:5], 3'h6);
		h.wr(A_CSC, 8'h50);
		repeat (3) @(posedge mclk);
		chk({7'h00, channel_irq}, 8'h00);
		h.wr(A_CNT_LO, 8'(($urandom)));
		h.rd(A_CNT_LO, d); chk(d, 8'h00);
		// capture on a rising edge stores the counter
		tick(6);
		h.wr(A_CSC, 8'h44);
		@(posedge mclk) cap_in <= 1'b1;
		repeat (2) @(posedge mclk);
		chk({7'h00, channel_irq}, 8'h01);
		h.rd(A_CHV_LO, d); chk(d, 8'h06);
		h.rd(A_CSC, d);
		h.wr(A_CSC, 8'h68);
		h.wr(A_CHV_HI, 8'h00);
		h.wr(A_CHV_LO, 8'h00);
		h.wr(A_CNT_LO, 8'h00);
		tick(int'(m) + 2);
		chk({7'h00, channel_irq}, 8'h00);
		h.wr(A_CHV_LO, 8'h02);
		h.wr(A_CNT_LO, 8'h00);
		tick(3);
		chk({7'h00, channel_irq}, 8'h01);
		h.wr(A_MSC, 8'h78);
		h.wr(A_CNT_LO, 8'h00);
		tick(int'(m) + 3);
		e = m - 16'h0003;
		h.rd(A_CNT_LO, d); chk(d, e[7:0]);
		h.rd(A_CNT_HI, d); chk(d, e[15:8]);
		h.wr(A_MSC, 8'h10);
		h.wr(A_CNT_LO, 8'h00);
		tick(5);
		h.rd(A_CNT_LO, d); chk(d, 8'h05);
		summarize();
	end
endmodule
